// ### hw/fsr_cfg.svh
// constants shared by both ends of the serial flash read link
`ifndef FSR_CFG_SVH
`define FSR_CFG_SVH
// ------------------------------------------------------------
// command codes
// ------------------------------------------------------------
`define FSR_OP_FAST 8'h0B
`define FSR_OP_RAND 8'h03
`define FSR_OP_COPY1 8'h53
`define FSR_OP_COPY2 8'h55
`define FSR_OP_BRD1 8'hD4
`define FSR_OP_BRD2 8'hD6
`define FSR_OP_BRL1 8'hD1
`define FSR_OP_BRL2 8'hD3
// ------------------------------------------------------------
// frame layout
// ------------------------------------------------------------
`define FSR_OP_BITS 6'h08
`define FSR_ADDR_BITS 6'h18
`define FSR_DUMMY_BITS 6'h08
`define FSR_MISO_IDLE 1'b1
// ------------------------------------------------------------
// array geometry
// ------------------------------------------------------------
`define FSR_PAGE_BYTES 256
`define FSR_PAGES 16
`define FSR_ARR_AW 12
`define FSR_FIFO_DEPTH 16
// ------------------------------------------------------------
// timing, clk_sys in MHz and link limits in MHz
// ------------------------------------------------------------
`define FSR_CLK_MHZ 200
`define FSR_FAST_MHZ 66
`define FSR_SLOW_MHZ 33
`define FSR_HALF_FAST ((`FSR_CLK_MHZ + 2 * `FSR_FAST_MHZ - 1) / (2 * `FSR_FAST_MHZ))
`define FSR_HALF_SLOW ((`FSR_CLK_MHZ + 2 * `FSR_SLOW_MHZ - 1) / (2 * `FSR_SLOW_MHZ))
`define FSR_MIN_HALF 7
`endif

// ### hw/fsr_pkg.sv
// types and command decode shared by both ends
`include "fsr_cfg.svh"
package fsr_pkg;
  // ------------------------------------------------------------
  // state machines
  // ------------------------------------------------------------
  typedef enum logic [6:0] {
    DS_IDLE = 7'h01, DS_CMD = 7'h02, DS_ADDR = 7'h04, DS_DUMMY = 7'h08,
    DS_DATA = 7'h10, DS_HOLD = 7'h20, DS_COPY = 7'h40
  } fsr_dev_st_e;
  typedef enum logic [4:0] {
    HS_IDLE = 5'h01, HS_SEL = 5'h02, HS_LOW = 5'h04, HS_HIGH = 5'h08, HS_STOP = 5'h10
  } fsr_host_st_e;
  typedef enum logic [1:0] {
    SRC_ARRAY = 2'h0, SRC_BUF1 = 2'h1, SRC_BUF2 = 2'h2, SRC_NONE = 2'h3
  } fsr_src_e;
  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  function automatic logic fsr_has_dummy(input logic [7:0] op);
    return op == `FSR_OP_FAST || op == `FSR_OP_BRD1 || op == `FSR_OP_BRD2;
  endfunction : fsr_has_dummy
  function automatic logic fsr_is_copy(input logic [7:0] op);
    return op == `FSR_OP_COPY1 || op == `FSR_OP_COPY2;
  endfunction : fsr_is_copy
  function automatic logic fsr_is_fast(input logic [7:0] op);
    return fsr_has_dummy(op);
  endfunction : fsr_is_fast
endpackage : fsr_pkg

// ### hw/fsr_link_if.sv
// four-wire serial link between flash master and flash device
`timescale 1ns/1ps
interface fsr_link_if;
  logic flash_select_n;
  logic sclk;
  logic mosi;
  logic miso;
  modport dev (input flash_select_n, input sclk, input mosi, output miso);
  modport host (output flash_select_n, output sclk, output mosi, input miso);
endinterface : fsr_link_if

// ### hw/fsr_fifo.sv
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module fsr_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // system
  input wire logic clk_sys,
  input wire logic resetn,
  // fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire [AW:0] next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  // flags registered from next count so both stay honest and glitch free
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) wp <= (wp == AW'(D - 1)) ? '0 : wp + 1'b1;
      if (pop) rp <= (rp == AW'(D - 1)) ? '0 : rp + 1'b1;
      cnt <= next_cnt;
      in_ready <= next_cnt != (AW + 1)'(D);
      out_valid <= next_cnt != '0;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (push) mem[wp] <= in_data;
  end
  assign out_data = mem[rp];
endmodule : fsr_fifo

// ### hw/fsr_flash_dev.sv
// serial flash device end: command decode, array and page buffer streaming
`timescale 1ns/1ps
`include "fsr_cfg.svh"
module fsr_flash_dev #(
  parameter bit TWO_BUFS = 1'b1
) (
  // system
  input wire logic clk_sys,
  input wire logic resetn,
  // link
  fsr_link_if.dev link,
  // array loading
  input wire logic load_en,
  input wire logic [`FSR_ARR_AW-1:0] load_addr,
  input wire logic [7:0] load_data,
  // status
  output logic copy_busy
);
  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [7:0] arr [`FSR_PAGES * `FSR_PAGE_BYTES];
  logic [7:0] buf1 [`FSR_PAGE_BYTES];
  logic [7:0] buf2 [`FSR_PAGE_BYTES];

  // ------------------------------------------------------------
  // pin synchronisers and edge detect
  // ------------------------------------------------------------
  logic cs_m, cs_s, sck_m, sck_s, sck_d, mo_m, mo_s;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      sck_m <= 1'b1;
      sck_s <= 1'b1;
      sck_d <= 1'b1;
      mo_m <= 1'b0;
      mo_s <= 1'b0;
    end else begin
      cs_m <= link.flash_select_n;
      cs_s <= cs_m;
      sck_m <= link.sclk;
      sck_s <= sck_m;
      sck_d <= sck_s;
      mo_m <= link.mosi;
      mo_s <= mo_m;
    end
  end
  wire sck_rise = sck_s & ~sck_d;
  wire sck_fall = ~sck_s & sck_d;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  fsr_pkg::fsr_dev_st_e state, next_state;
  logic [5:0] cnt;
  logic [7:0] cmd;
  logic [23:0] addr;
  fsr_pkg::fsr_src_e src;
  logic [`FSR_ARR_AW-1:0] ptr;
  logic [2:0] bitpos;
  logic [7:0] cpy_i;
  logic [3:0] cpy_page;
  logic cpy_sel2;
  logic miso;

  function automatic fsr_pkg::fsr_src_e op_src(input logic [7:0] op, input logic two);
    fsr_pkg::fsr_src_e s;
    s = fsr_pkg::SRC_NONE;
    if (op == `FSR_OP_FAST || op == `FSR_OP_RAND) s = fsr_pkg::SRC_ARRAY;
    if (op == `FSR_OP_BRD1 || op == `FSR_OP_BRL1 || op == `FSR_OP_COPY1) s = fsr_pkg::SRC_BUF1;
    if (two && (op == `FSR_OP_BRD2 || op == `FSR_OP_BRL2 || op == `FSR_OP_COPY2)) begin
      s = fsr_pkg::SRC_BUF2;
    end
    return s;
  endfunction : op_src

  wire [7:0] cmd_full = {cmd[6:0], mo_s};
  wire fsr_pkg::fsr_src_e cmd_src = op_src(cmd_full, TWO_BUFS);
  wire [23:0] addr_full = {addr[22:0], mo_s};
  wire last_op = cnt == `FSR_OP_BITS - 6'h01;
  wire last_addr = cnt == `FSR_ADDR_BITS - 6'h01;
  wire last_dummy = cnt == `FSR_DUMMY_BITS - 6'h01;
  wire has_dummy = fsr_pkg::fsr_has_dummy(cmd);
  wire is_copy = fsr_pkg::fsr_is_copy(cmd);
  wire cpy_done = cpy_i == 8'hFF;

  // byte under the read pointer; fast and random reads look only at the array
  wire [7:0] cur_byte = (src == fsr_pkg::SRC_ARRAY) ? arr[ptr] :
                        (src == fsr_pkg::SRC_BUF1) ? buf1[ptr[7:0]] : buf2[ptr[7:0]];
  // array reads run over pages and wrap at the top, buffer reads stay in one page
  wire [`FSR_ARR_AW-1:0] ptr_inc = (src == fsr_pkg::SRC_ARRAY) ? ptr + 1'b1 :
                                   {ptr[`FSR_ARR_AW-1:8], ptr[7:0] + 8'h01};

  // ------------------------------------------------------------
  // state machine
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      fsr_pkg::DS_IDLE: begin
        if (!cs_s) next_state = fsr_pkg::DS_CMD;
      end
      fsr_pkg::DS_CMD: begin
        if (cs_s) next_state = fsr_pkg::DS_IDLE;
        else if (sck_rise && last_op) begin
          next_state = (cmd_src == fsr_pkg::SRC_NONE) ? fsr_pkg::DS_HOLD : fsr_pkg::DS_ADDR;
        end
      end
      fsr_pkg::DS_ADDR: begin
        if (cs_s) next_state = fsr_pkg::DS_IDLE;
        else if (sck_rise && last_addr) begin
          if (is_copy) next_state = fsr_pkg::DS_HOLD;
          else if (has_dummy) next_state = fsr_pkg::DS_DUMMY;
          else next_state = fsr_pkg::DS_DATA;
        end
      end
      fsr_pkg::DS_DUMMY: begin
        if (cs_s) next_state = fsr_pkg::DS_IDLE;
        else if (sck_rise && last_dummy) next_state = fsr_pkg::DS_DATA;
      end
      fsr_pkg::DS_DATA: begin
        if (cs_s) next_state = fsr_pkg::DS_IDLE;
      end
      fsr_pkg::DS_HOLD: begin
        // a copy only starts once select rises, as the code is complete then
        if (cs_s) next_state = (is_copy && src != fsr_pkg::SRC_NONE) ?
                               fsr_pkg::DS_COPY : fsr_pkg::DS_IDLE;
      end
      fsr_pkg::DS_COPY: begin
        if (cpy_done) next_state = fsr_pkg::DS_IDLE;
      end
      default: next_state = fsr_pkg::DS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) state <= fsr_pkg::DS_IDLE;
    else state <= next_state;
  end

  // ------------------------------------------------------------
  // shift registers and counters
  // ------------------------------------------------------------
  wire phase_chg = next_state != state;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt <= 6'h00;
      cmd <= 8'h00;
      addr <= 24'h000000;
      src <= fsr_pkg::SRC_NONE;
    end else begin
      if (phase_chg) cnt <= 6'h00;
      else if (sck_rise) cnt <= cnt + 6'h01;
      if (state == fsr_pkg::DS_CMD && sck_rise) cmd <= cmd_full;
      if (state == fsr_pkg::DS_CMD && sck_rise && last_op) src <= cmd_src;
      // mosi is not looked at outside the opcode and address phases
      if (state == fsr_pkg::DS_ADDR && sck_rise) addr <= addr_full;
    end
  end

  // ------------------------------------------------------------
  // data out, one bit per falling edge
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ptr <= '0;
      bitpos <= 3'h0;
      miso <= `FSR_MISO_IDLE;
    end else begin
      if (state == fsr_pkg::DS_ADDR && sck_rise && last_addr) begin
        ptr <= addr_full[`FSR_ARR_AW-1:0];
        bitpos <= 3'h0;
      end
      if (state == fsr_pkg::DS_DATA && !cs_s) begin
        if (sck_fall) begin
          miso <= cur_byte[3'h7 - bitpos];
          bitpos <= bitpos + 3'h1;
          if (bitpos == 3'h7) ptr <= ptr_inc;
        end
      end else begin
        miso <= `FSR_MISO_IDLE;
      end
    end
  end
  assign link.miso = miso;

  // ------------------------------------------------------------
  // page copy into a buffer, one byte per clock
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cpy_i <= 8'h00;
      cpy_page <= 4'h0;
      cpy_sel2 <= 1'b0;
      copy_busy <= 1'b0;
    end else begin
      if (state == fsr_pkg::DS_HOLD && next_state == fsr_pkg::DS_COPY) begin
        cpy_i <= 8'h00;
        cpy_page <= addr[11:8]; // byte field of the address is ignored
        cpy_sel2 <= src == fsr_pkg::SRC_BUF2;
      end else if (state == fsr_pkg::DS_COPY) begin
        cpy_i <= cpy_i + 8'h01;
      end
      copy_busy <= next_state == fsr_pkg::DS_COPY;
    end
  end

  // only the copy writes the buffers; the buffer reads only read them
  always_ff @(posedge clk_sys) begin
    if (state == fsr_pkg::DS_COPY && !cpy_sel2) buf1[cpy_i] <= arr[{cpy_page, cpy_i}];
    if (state == fsr_pkg::DS_COPY && cpy_sel2) buf2[cpy_i] <= arr[{cpy_page, cpy_i}];
  end

  always_ff @(posedge clk_sys) begin
    if (load_en) arr[load_addr] <= load_data;
  end
endmodule : fsr_flash_dev

// ### hw/fsr_host.sv
// serial flash master end: frames commands and queues returned bytes
`timescale 1ns/1ps
`include "fsr_cfg.svh"
module fsr_host (
  // system
  input wire logic clk_sys,
  input wire logic resetn,
  // link
  fsr_link_if.host link,
  // command
  input wire logic start,
  input wire logic [7:0] op,
  input wire logic [23:0] addr,
  input wire logic [15:0] len,
  output logic busy,
  // read data
  output logic rd_valid,
  output logic [7:0] rd_data,
  input wire logic rd_ready
);
  // ------------------------------------------------------------
  // clocking
  // ------------------------------------------------------------
  // half period is kept long enough for the device's pin sampling lag
  localparam int HF = (`FSR_HALF_FAST > `FSR_MIN_HALF) ? `FSR_HALF_FAST : `FSR_MIN_HALF;
  localparam int HS = (`FSR_HALF_SLOW > `FSR_MIN_HALF) ? `FSR_HALF_SLOW : `FSR_MIN_HALF;
  fsr_pkg::fsr_host_st_e state;
  logic [3:0] half, dcnt;
  logic [39:0] tx;
  logic [19:0] tot, bitn, hdr;
  logic [7:0] rx;
  logic [2:0] rxn;
  logic cs_n, sclk, mosi, mi_m, mi_s;
  wire tick = dcnt == 4'h0;
  wire in_data = bitn >= hdr;
  wire fifo_ready;
  wire hold = in_data && rxn == 3'h7 && !fifo_ready;
  wire push = state == fsr_pkg::HS_HIGH && tick && in_data && rxn == 3'h7 && fifo_ready;
  wire last = bitn == tot - 20'h00001;
  wire fast = fsr_pkg::fsr_is_fast(op);
  wire [3:0] next_half = fast ? 4'(HF) : 4'(HS);
  wire [19:0] next_hdr = fsr_pkg::fsr_has_dummy(op) ? 20'h00028 : 20'h00020;
  wire [19:0] data_bits = fsr_pkg::fsr_is_copy(op) ? 20'h00000 : {1'b0, len, 3'h0};

  // ------------------------------------------------------------
  // miso synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mi_m <= 1'b1;
      mi_s <= 1'b1;
    end else begin
      mi_m <= link.miso;
      mi_s <= mi_m;
    end
  end

  // ------------------------------------------------------------
  // divider
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) dcnt <= 4'h0;
    else if (state == fsr_pkg::HS_IDLE) dcnt <= next_half - 4'h1;
    else if (tick && !(state == fsr_pkg::HS_HIGH && hold)) dcnt <= half - 4'h1;
    else if (!tick) dcnt <= dcnt - 4'h1;
  end

  // ------------------------------------------------------------
  // frame sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= fsr_pkg::HS_IDLE;
      cs_n <= 1'b1;
      sclk <= 1'b1;
      mosi <= 1'b0;
      busy <= 1'b0;
      half <= 4'h1;
      tx <= 40'h0000000000;
      tot <= 20'h00000;
      hdr <= 20'h00000;
      bitn <= 20'h00000;
      rx <= 8'h00;
      rxn <= 3'h0;
    end else begin
      case (state)
        fsr_pkg::HS_IDLE: begin
          if (start) begin
            cs_n <= 1'b0;
            tx <= {op, addr, 8'h00};
            hdr <= next_hdr;
            tot <= next_hdr + data_bits;
            half <= next_half;
            bitn <= 20'h00000;
            rxn <= 3'h0;
            busy <= 1'b1;
            state <= fsr_pkg::HS_SEL;
          end
        end
        fsr_pkg::HS_SEL: begin
          if (tick) begin
            sclk <= 1'b0;
            mosi <= tx[39];
            tx <= {tx[38:0], 1'b0};
            state <= fsr_pkg::HS_LOW;
          end
        end
        fsr_pkg::HS_LOW: begin
          if (tick) begin
            sclk <= 1'b1;
            state <= fsr_pkg::HS_HIGH;
          end
        end
        fsr_pkg::HS_HIGH: begin
          // a full fifo parks the clock high, so the device holds its bit
          if (tick && !hold) begin
            if (in_data) begin
              rx <= {rx[6:0], mi_s};
              rxn <= rxn + 3'h1;
            end
            bitn <= bitn + 20'h00001;
            sclk <= 1'b0;
            if (last) begin
              cs_n <= 1'b1;
              state <= fsr_pkg::HS_STOP;
            end else begin
              mosi <= tx[39];
              tx <= {tx[38:0], 1'b0};
              state <= fsr_pkg::HS_LOW;
            end
          end
        end
        fsr_pkg::HS_STOP: begin
          if (tick) begin
            sclk <= 1'b1;
            busy <= 1'b0;
            state <= fsr_pkg::HS_IDLE;
          end
        end
        default: state <= fsr_pkg::HS_IDLE;
      endcase
    end
  end
  assign link.flash_select_n = cs_n;
  assign link.sclk = sclk;
  assign link.mosi = mosi;

  // ------------------------------------------------------------
  // read data queue
  // ------------------------------------------------------------
  fsr_fifo #(
    .W(8),
    .D(`FSR_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .in_valid(push),
    .in_data({rx[6:0], mi_s}),
    .in_ready(fifo_ready),
    .out_valid(rd_valid),
    .out_data(rd_data),
    .out_ready(rd_ready)
  );
endmodule : fsr_host

// ### tb/fsr_link_properties.sv
// checker of the serial flash link between host and device ends
`timescale 1ns/1ps
`include "fsr_cfg.svh"
module fsr_link_properties (
  // system
  input wire logic clk_sys,
  input wire logic resetn,
  // link
  input wire logic flash_select_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso
);
  // ------------------------------------------------------------
  // frame tracking
  // ------------------------------------------------------------
  logic sclk_q;
  logic [15:0] n_rise;
  logic [7:0] op_seen;
  wire rise_w = sclk && !sclk_q;
  wire dummy_w = op_seen == `FSR_OP_FAST || op_seen == `FSR_OP_BRD1 || op_seen == `FSR_OP_BRD2;
  wire [15:0] hdr_w = dummy_w ? 16'h0028 : 16'h0020;
  // counts serial clock rises inside a frame; cleared while select is high
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sclk_q <= 1'b1;
      n_rise <= 16'h0000;
      op_seen <= 8'h00;
    end else begin
      sclk_q <= sclk;
      n_rise <= flash_select_n ? 16'h0000 : n_rise + 16'(rise_w);
      op_seen <= (rise_w && n_rise < 16'h0008) ? {op_seen[6:0], mosi} : op_seen;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  sel_fall_a: assert property ($fell(flash_select_n) |-> sclk)
    else $error("select lowered while serial clock low");
  sel_rise_a: assert property ($rose(flash_select_n) |-> $fell(sclk))
    else $error("select raised off a falling clock edge");
  mosi_edge_a: assert property (!flash_select_n && $changed(mosi) |-> $fell(sclk))
    else $error("master data moved off a falling edge");
  clk_low_a: assert property ($fell(sclk) |-> !sclk [*7] ##1 sclk)
    else $error("serial clock low phase not seven cycles");
  clk_high_a: assert property ($rose(sclk) |-> sclk [*7])
    else $error("serial clock high phase too short");
  frame_len_a: assert property ($rose(flash_select_n) |-> n_rise >= 16'h0020 && n_rise[2:0] == 3'h0)
    else $error("frame ended off a byte boundary or inside the header");
  miso_phase_a: assert property (!flash_select_n && !miso |-> n_rise >= hdr_w)
    else $error("device data driven during header or dummy bits");
  miso_edge_a: assert property (!flash_select_n && $changed(miso) |-> !$past(sclk, 3))
    else $error("device data moved away from a falling edge");
  miso_idle_a: assert property (flash_select_n [*5] |-> miso)
    else $error("device data not high after select rise");
endmodule : fsr_link_properties

// ### tb/flash_serial_read_port_tb.sv
// self-checking bench: host and device joined across the serial link
`timescale 1ns/1ps
`include "fsr_cfg.svh"
module flash_serial_read_port_tb;
  // ------------------------------------------------------------
  // signals, mirrors and instances
  // ------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic start = 1'b0;
  logic [7:0] op = 8'h00;
  logic [23:0] addr = 24'h000000;
  logic [15:0] len = 16'h0000;
  logic rd_ready = 1'b0;
  logic load_en = 1'b0;
  logic [11:0] load_addr = 12'h000;
  logic [7:0] load_data = 8'h00;
  logic hold_off = 1'b1;
  logic busy, rd_valid, copy_busy, copy_busy_solo;
  logic [7:0] rd_data;
  logic [7:0] mem [4096];
  logic [7:0] buf1 [256];
  logic [7:0] buf2 [256];
  logic [7:0] exp_q [$];
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  always #2.5 clk_sys = ~clk_sys;
  fsr_link_if link ();
  fsr_link_if link_solo ();
  fsr_host fsr_host_i (.clk_sys, .resetn, .link(link.host), .start, .op, .addr, .len, .busy,
    .rd_valid, .rd_data, .rd_ready);
  fsr_flash_dev fsr_flash_dev_i (.clk_sys, .resetn, .link(link.dev), .load_en, .load_addr,
    .load_data, .copy_busy);
  // single-buffer variant, driven by the bench as a master that may misbehave
  fsr_flash_dev #(.TWO_BUFS(1'b0)) fsr_flash_dev_solo_i (.clk_sys, .resetn,
    .link(link_solo.dev), .load_en, .load_addr, .load_data, .copy_busy(copy_busy_solo));
  fsr_link_properties fsr_link_properties_i (.clk_sys, .resetn,
    .flash_select_n(link.flash_select_n), .sclk(link.sclk), .mosi(link.mosi), .miso(link.miso));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask : chk
  task automatic end_of_test();
    // bytes still owed by the host mean a frame stalled or lost data
    if (exp_q.size() != 0) begin
      n_errors++;
      $display("Error rd_count expected 0 seen %0d", exp_q.size());
    end
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  // notes the expected bytes, then pulses start right after an edge
  task automatic cmd(input logic [7:0] o, input logic [23:0] a, input int n, input int src);
    int k;
    for (k = 0; k < n; k++) begin
      if (src == 0) exp_q.push_back(mem[a[11:0] + 12'(k)]);
      else if (src == 1) exp_q.push_back(buf1[a[7:0] + 8'(k)]);
      else exp_q.push_back(buf2[a[7:0] + 8'(k)]);
    end
    start <= 1'b1;
    op <= o;
    addr <= a;
    len <= 16'(n);
    @(posedge clk_sys);
    start <= 1'b0;
  endtask : cmd
  task automatic wait_idle();
    int t;
    // busy rises only at the edge that takes start, so let that edge pass first
    @(posedge clk_sys);
    for (t = 0; t < 30000 && busy !== 1'b0; t++) @(posedge clk_sys);
  endtask : wait_idle
  task automatic wait_copy();
    int t;
    for (t = 0; t < 20 && copy_busy !== 1'b1; t++) @(posedge clk_sys);
    chk("copy_busy", {7'h00, copy_busy}, 8'h01);
    for (t = 0; t < 600 && copy_busy !== 1'b0; t++) @(posedge clk_sys);
  endtask : wait_copy
  // bench-made link clock, 64 ns period, unrelated to clk_sys
  task automatic bang(input logic [7:0] tx, input int n, output logic [7:0] rx);
    int b;
    rx = 8'h00;
    for (b = 7; b > 7 - n; b--) begin
      link_solo.sclk = 1'b0;
      link_solo.mosi = tx[b];
      #32;
      link_solo.sclk = 1'b1;
      #32;
      rx[b] = link_solo.miso;
    end
  endtask : bang
  task automatic solo_frame(input logic [7:0] o, input logic [11:0] a, output logic [7:0] rx);
    logic [7:0] d;
    link_solo.flash_select_n = 1'b0;
    #32;
    bang(o, 8, d);
    bang(8'h00, 8, d);
    bang({4'h0, a[11:8]}, 8, d);
    bang(a[7:0], 8, d);
    bang(8'($urandom), 8, d);
    bang(8'($urandom), 8, rx);
  endtask : solo_frame
  task automatic solo_end();
    link_solo.sclk = 1'b0;
    link_solo.flash_select_n = 1'b1;
    #64;
    link_solo.sclk = 1'b1;
    link_solo.mosi = ~link_solo.mosi;
  endtask : solo_end
  // ------------------------------------------------------------
  // timeout and result monitor
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      end_of_test();
    end
  end
  always @(posedge clk_sys) begin
    rd_ready <= !hold_off && ($urandom_range(0, 3) != 0);
    if (resetn && rd_valid === 1'b1 && rd_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("Error rd_data expected none seen %h", rd_data);
      end else begin
        chk("rd_data", rd_data, exp_q.pop_front());
      end
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    int i;
    logic [7:0] got;
    logic [7:0] t_op [11];
    logic [23:0] t_ad [11];
    int t_n [11];
    int t_src [11];
    link_solo.flash_select_n = 1'b1;
    link_solo.sclk = 1'b1;
    link_solo.mosi = 1'b0;
    void'($urandom(91757));
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    hold_off <= 1'b0;
    for (i = 0; i < 4096; i++) begin
      @(posedge clk_sys);
      mem[i] = 8'($urandom);
      load_en <= 1'b1;
      load_addr <= 12'(i);
      load_data <= mem[i];
    end
    @(posedge clk_sys);
    load_en <= 1'b0;
    // byte field of a copy is ignored, so odd offsets are used on purpose
    cmd(8'h53, 24'h000533, 0, 0);
    wait_idle();
    wait_copy();
    cmd(8'h55, 24'h000977, 0, 0);
    wait_idle();
    wait_copy();
    for (i = 0; i < 256; i++) begin
      buf1[i] = mem[{4'h5, 8'(i)}];
      buf2[i] = mem[{4'h9, 8'(i)}];
    end
    $display("test page_copy done");
    t_op = '{8'h0B, 8'h0B, 8'h0B, 8'h0B, 8'h03, 8'hD4, 8'hD1, 8'hD6, 8'hD3, 8'h0B, 8'hD4};
    t_ad = '{24'($urandom), 24'h0001FE, 24'hABCFFE, 24'h000010, 24'h000FFF, 24'h0000FE,
      24'h0000FE, 24'h0000FE, 24'h0000FE, 24'h000500, 24'h000000};
    t_n = '{5, 4, 4, 0, 3, 3, 3, 3, 3, 2, 2};
    t_src = '{0, 0, 0, 0, 0, 1, 1, 2, 2, 0, 1};
    for (i = 0; i < 11; i++) begin
      cmd(t_op[i], t_ad[i], t_n[i], t_src[i]); // each read kind
      wait_idle(); // back to back frames
    end
    $display("test read_kinds done");
    hold_off <= 1'b1;
    cmd(8'h0B, 24'h000F00, 20, 0);
    @(posedge clk_sys);
    // second start lands mid-frame and must be ignored
    cmd(8'h03, 24'h000000, 0, 0);
    repeat (3000) @(posedge clk_sys);
    got = {6'h00, busy, link.sclk};
    repeat (20) @(posedge clk_sys);
    chk("parked_link", {6'h00, busy, link.sclk}, got);
    chk("parked_state", got, 8'h03);
    hold_off <= 1'b0;
    wait_idle();
    for (i = 0; i < 5000 && exp_q.size() != 0; i++) @(posedge clk_sys);
    $display("test fifo_full done");
    solo_frame(8'h0B, 12'h123, got);
    chk("solo_first", got, mem[12'h123]);
    bang(8'($urandom), 3, got);
    chk("solo_part", got & 8'hE0, mem[12'h124] & 8'hE0);
    solo_end();
    chk("solo_idle", {7'h00, link_solo.miso}, 8'h01);
    #200;
    solo_frame(8'hD6, 12'h000, got);
    chk("solo_buf2", got, 8'hFF);
    solo_end();
    #200;
    solo_frame(8'h55, 12'h300, got);
    solo_end();
    #100;
    chk("solo_copy", {7'h00, copy_busy_solo}, 8'h00);
    $display("test solo_link done");
    end_of_test();
  end
endmodule : flash_serial_read_port_tb
